// *** logic/timer_cfg.svh ***
/*
  register indices, field positions, reset values and timing counts of the timer.
  assumes: byte address of a register is four times its index; clock is high_freq_clock.
*/
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH

// register indices
`define IDX_CMP_LO       6'h10
`define IDX_CMP_HI       6'h11
`define IDX_CAP_LO       6'h12
`define IDX_CAP_HI       6'h13
`define IDX_CTRL         6'h26
`define IDX_SYSCTL       6'h30
`define IDX_CNT_LO       6'h31
`define IDX_CNT_HI       6'h32
`define IDX_STATUS       6'h33

// timer_control_register fields
`define CTRL_MODE_POS    0
`define CTRL_CLK_POS     2
`define CTRL_START_POS   4
`define CTRL_SHARED_POS  6
`define CTRL_TFF_POS     7

// system control fields
`define SYS_PSEL_POS     0
`define SYS_LOWSPD_POS   1
`define SYS_STOP_POS     2

// status fields
`define STAT_RUN_POS     0
`define STAT_MATCH_POS   1
`define STAT_CPEND_POS   2
`define STAT_BPEND_POS   3

// reset values
`define RST_TIMER_REG    16'hFFFF
`define RST_CTRL         8'h00
`define RST_SYSCTL       2'h0

// field encodings
`define START_STOP       2'h0
`define START_CMD        2'h1
`define START_RISE       2'h2
`define START_FALL       2'h3
`define MODE_TIMER       2'h0
`define MODE_WINDOW      2'h1
`define MODE_PULSE       2'h2
`define MODE_PPG         2'h3
`define CLK_DIV11        2'h0
`define CLK_DIV7         2'h1
`define CLK_DIV3         2'h2
`define CLK_PIN          2'h3

// timing, in high_freq_clock periods
`define NOISE_REJECT_FC  4
`define EDGE_GUARANTEE_FC 12
`define FILTER_CYCLES    ((`NOISE_REJECT_FC + `EDGE_GUARANTEE_FC) / 2)

`endif

// *** logic/timer_pkg.sv ***
/*
  types shared by the timer and its input filter.
  assumes: nothing beyond a SystemVerilog compiler.
*/
package timer_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_WAIT  = 3'b010,
    ST_COUNT = 3'b100
  } run_state_e;

  typedef struct packed {
    run_state_e  run;
    logic [15:0] cnt;
    logic [15:0] cmp_eff;
    logic [15:0] cmp_buf;
    logic        cmp_pend;
    logic [15:0] cap_eff;
    logic [15:0] cap_buf;
    logic        cap_pend;
    logic [7:0]  ctrl;
    logic [1:0]  sysctl;
    logic [10:0] pre;
    logic [2:0]  fs_sync;
    logic        fs_lvl;
    logic [2:0]  fs_div;
    logic        match_seen;
    logic        irq;
    logic        ack;
    logic [31:0] rdata;
  } timer_state_s;

  typedef struct packed {
    logic [2:0] sync;
    logic       lvl;
    logic [3:0] cnt;
    logic       rise;
    logic       fall;
  } filt_state_s;

endpackage

// *** logic/pin_edge_if.sv ***
/*
  filtered level and edge pulses of the timer input pin.
  assumes: both ends run on the same clock.
*/
`timescale 1ns/1ps
interface pin_edge_if;
  logic level;
  logic rise;
  logic fall;
  modport source (output level, output rise, output fall);
  modport sink   (input level, input rise, input fall);
endinterface

// *** logic/pin_filter.sv ***
/*
  three-stage synchroniser and noise filter for the timer input pin.
  assumes: pin is asynchronous to clock; bypass is a quasi-static level.
*/
`timescale 1ns/1ps
`include "timer_cfg.svh"
module pin_filter #(
  parameter int FILTER_CYCLES = `FILTER_CYCLES
) (
  input  wire logic   clock,           // high_freq_clock
  input  wire logic   reset,           // async, active high
  input  wire logic   timer_input_pin, // raw pin
  input  wire logic   bypass,          // low-speed modes: no filter
  pin_edge_if.source  edges            // filtered level and edges
);
  import timer_pkg::*;

  localparam logic [3:0] LAST = 4'(FILTER_CYCLES - 1);

  filt_state_s s_q;
  filt_state_s s_d;

  always_comb begin
    s_d      = s_q;
    s_d.rise = 1'b0;
    s_d.fall = 1'b0;
    s_d.sync = {s_q.sync[1:0], timer_input_pin};
    // second and third stage agree on a new level
    if (s_q.sync[1] == s_q.sync[2] && s_q.sync[2] != s_q.lvl) begin
      if (bypass || s_q.cnt == LAST) begin
        s_d.lvl  = s_q.sync[2];
        s_d.rise = s_q.sync[2];
        s_d.fall = ~s_q.sync[2];
        s_d.cnt  = 4'h0;
      end else begin
        s_d.cnt = s_q.cnt + 4'h1;
      end
    end else begin
      s_d.cnt = 4'h0;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign edges.level = s_q.lvl;
  assign edges.rise  = s_q.rise;
  assign edges.fall  = s_q.fall;
endmodule

// *** logic/timer_counter.sv ***
/*
  16-bit up-counter timer: timer and external trigger modes, buffered compare,
  auto-capture, classic wishbone register slave.
  assumes: clock is high_freq_clock; low_freq_clock and timer_input_pin asynchronous.
*/
// What this block does
// - timer registers buffered; new value applied at first source tick after upper write.
// - lower-byte write alone never changes the effective register value.
// - auto-capture works only in timer and event counter modes, not in window mode.
// - stop power mode entry clears start field to stop and halts timer.
// - auto-capture copies counter each source tick; software waits one tick first.
// - timer mode counts source ticks; on match raise interrupt, clear, continue.
// - with auto-capture enabled the running count loads the capture register.
// - external trigger mode starts counting on selected pin edge.
// - external trigger mode match clears, halts and raises interrupt.
// - with trigger stop, opposite edge before match clears and halts silently.
// - with trigger stop, halted counter restarts from zero on next trigger edge.
// - trigger start only: opposite edges and early trigger edges are ignored.
// - pin pulses of four clocks or less rejected; twelve clocks always seen.
// - low-speed modes bypass the noise filter.
// - source clock select: div 2^11 or fs/8, div 2^7, div 2^3, pin.
// - start field: stop and clear, command, rising edge, falling edge.
// - mode field: timer group, window, pulse width, pulse generator.
`timescale 1ns/1ps
`include "timer_cfg.svh"
module timer_counter #(
  parameter int FILTER_CYCLES = `FILTER_CYCLES
) (
  input  wire logic        clock,           // high_freq_clock, 200 MHz
  input  wire logic        reset,           // async, active high
  input  wire logic        wb_cyc,          // wishbone cycle
  input  wire logic        wb_stb,          // wishbone strobe
  input  wire logic        wb_we,           // wishbone write
  input  wire logic [7:0]  wb_adr,          // byte address
  input  wire logic [3:0]  wb_sel,          // byte selects
  input  wire logic [31:0] wb_dat_w,        // write data
  output logic      [31:0] wb_dat_r,        // read data
  output logic             wb_ack,          // acknowledge
  input  wire logic        low_freq_clock,  // fs, asynchronous
  input  wire logic        timer_input_pin, // trigger pin
  output logic             match_interrupt  // one-cycle pulse on match
);
  import timer_pkg::*;

  timer_state_s s_q;
  timer_state_s s_d;

  pin_edge_if pin ();

  pin_filter #(
    .FILTER_CYCLES (FILTER_CYCLES)
  ) u_filter (
    .clock           (clock),
    .reset           (reset),
    .timer_input_pin (timer_input_pin),
    .bypass          (s_q.sysctl[`SYS_LOWSPD_POS]),
    .edges           (pin)
  );

  logic [1:0]  mode;
  logic [1:0]  clk_sel;
  logic [1:0]  start;
  logic        shared_bit;
  logic        low_speed;
  logic        fs_rise;
  logic        tick;
  logic        ext_mode;
  logic        trig;
  logic        opp;
  logic        capture_ok;
  logic        req;
  logic        wr;
  logic [5:0]  idx;
  logic [7:0]  wbyte;
  logic [7:0]  rd;

  always_comb begin
    s_d        = s_q;
    mode       = s_q.ctrl[`CTRL_MODE_POS +: 2];
    clk_sel    = s_q.ctrl[`CTRL_CLK_POS +: 2];
    start      = s_q.ctrl[`CTRL_START_POS +: 2];
    shared_bit = s_q.ctrl[`CTRL_SHARED_POS];
    low_speed  = s_q.sysctl[`SYS_LOWSPD_POS];
    fs_rise    = 1'b0;
    tick       = 1'b0;
    req        = wb_cyc & wb_stb;
    wr         = req & s_q.ack & wb_we & wb_sel[0];
    idx        = wb_adr[7:2];
    wbyte      = wb_dat_w[7:0];
    rd         = 8'h00;
    s_d.irq    = 1'b0;

    // low_freq_clock: three stages, change taken when stages two and three agree
    s_d.fs_sync = {s_q.fs_sync[1:0], low_freq_clock};
    if (s_q.fs_sync[1] == s_q.fs_sync[2] && s_q.fs_sync[2] != s_q.fs_lvl) begin
      s_d.fs_lvl = s_q.fs_sync[2];
      fs_rise    = s_q.fs_sync[2];
    end
    if (fs_rise) begin
      s_d.fs_div = s_q.fs_div + 3'h1;
    end

    // source tick
    s_d.pre = s_q.pre + 11'h001;
    case (clk_sel)
      `CLK_DIV11: begin
        if (low_speed || s_q.sysctl[`SYS_PSEL_POS]) begin
          tick = fs_rise && (s_q.fs_div == 3'h7);
        end else begin
          tick = (s_q.pre == 11'h7FF);
        end
      end
      `CLK_DIV7: tick = !low_speed && (s_q.pre[6:0] == 7'h7F);
      `CLK_DIV3: tick = !low_speed && (s_q.pre[2:0] == 3'h7);
      default:   tick = pin.rise;
    endcase

    // buffered timer registers take effect on a source tick
    if (tick && s_q.cmp_pend) begin
      s_d.cmp_eff  = s_q.cmp_buf;
      s_d.cmp_pend = 1'b0;
    end
    if (tick && s_q.cap_pend) begin
      s_d.cap_eff  = s_q.cap_buf;
      s_d.cap_pend = 1'b0;
    end

    ext_mode = (start == `START_RISE) || (start == `START_FALL);
    trig     = (start == `START_RISE) ? pin.rise : pin.fall;
    opp      = (start == `START_RISE) ? pin.fall : pin.rise;

    case (s_q.run)
      ST_IDLE: begin
        if (mode == `MODE_TIMER && start == `START_CMD) begin
          s_d.run = ST_COUNT;
          s_d.cnt = 16'h0000;
        end else if (mode == `MODE_TIMER && ext_mode) begin
          s_d.run = ST_WAIT;
          s_d.cnt = 16'h0000;
        end
      end
      ST_WAIT: begin
        if (trig) begin
          s_d.run = ST_COUNT;
          s_d.cnt = 16'h0000;
        end
      end
      ST_COUNT: begin
        if (ext_mode && shared_bit && opp) begin
          s_d.run = ST_WAIT;
          s_d.cnt = 16'h0000;
        end else if (tick) begin
          if (s_q.cnt == s_q.cmp_eff) begin
            s_d.cnt        = 16'h0000;
            s_d.irq        = 1'b1;
            s_d.match_seen = 1'b1;
            if (ext_mode) begin
              s_d.run = ST_WAIT;
            end
          end else begin
            s_d.cnt = s_q.cnt + 16'h0001;
          end
        end
      end
      default: begin
        s_d.run = ST_IDLE;
      end
    endcase

    if (start == `START_STOP || mode != `MODE_TIMER) begin
      s_d.run        = ST_IDLE;
      s_d.cnt        = 16'h0000;
      // no match pulse once the start field reads stop
      s_d.irq        = 1'b0;
      s_d.match_seen = s_q.match_seen;
    end

    // auto-capture: timer command mode only; window mode never has run in ST_COUNT
    capture_ok = ((mode == `MODE_TIMER && start == `START_CMD) ||
                  mode == `MODE_WINDOW);
    if (shared_bit && capture_ok && tick && s_q.run == ST_COUNT) begin
      s_d.cap_eff = s_q.cnt;
    end

    // register read mux
    case (idx)
      `IDX_CMP_LO: rd = s_q.cmp_eff[7:0];
      `IDX_CMP_HI: rd = s_q.cmp_eff[15:8];
      `IDX_CAP_LO: rd = s_q.cap_eff[7:0];
      `IDX_CAP_HI: rd = s_q.cap_eff[15:8];
      `IDX_CTRL:   rd = s_q.ctrl;
      `IDX_SYSCTL: rd = {6'h00, s_q.sysctl};
      `IDX_CNT_LO: rd = s_q.cnt[7:0];
      `IDX_CNT_HI: rd = s_q.cnt[15:8];
      `IDX_STATUS: rd = {4'h0, s_q.cap_pend, s_q.cmp_pend, s_q.match_seen,
                         (s_q.run == ST_COUNT)};
      default:     rd = 8'h00;
    endcase

    // wishbone: ack one cycle after request, write commits on the ack edge
    s_d.ack = req & ~s_q.ack;
    if (req && !s_q.ack) begin
      s_d.rdata = {24'h00_0000, rd};
    end
    if (wr) begin
      case (idx)
        `IDX_CMP_LO: s_d.cmp_buf[7:0] = wbyte;
        `IDX_CMP_HI: begin
          s_d.cmp_buf[15:8] = wbyte;
          s_d.cmp_pend      = 1'b1;
        end
        `IDX_CAP_LO: begin
          if (mode == `MODE_PPG) begin
            s_d.cap_buf[7:0] = wbyte;
          end
        end
        `IDX_CAP_HI: begin
          if (mode == `MODE_PPG) begin
            s_d.cap_buf[15:8] = wbyte;
            s_d.cap_pend      = 1'b1;
          end
        end
        `IDX_CTRL: s_d.ctrl = wbyte;
        `IDX_SYSCTL: begin
          s_d.sysctl = wbyte[1:0];
          if (wbyte[`SYS_STOP_POS]) begin
            s_d.ctrl[`CTRL_START_POS +: 2] = `START_STOP;
          end
        end
        `IDX_STATUS: begin
          // set wins over clear
          if (wbyte[`STAT_MATCH_POS] && !s_d.irq) begin
            s_d.match_seen = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s_q            <= '0;
      s_q.run        <= ST_IDLE;
      s_q.cmp_eff    <= `RST_TIMER_REG;
      s_q.cmp_buf    <= `RST_TIMER_REG;
      s_q.cap_eff    <= `RST_TIMER_REG;
      s_q.cap_buf    <= `RST_TIMER_REG;
      s_q.ctrl       <= `RST_CTRL;
      s_q.sysctl     <= `RST_SYSCTL;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_dat_r        = s_q.rdata;
  assign wb_ack          = s_q.ack;
  assign match_interrupt = s_q.irq;
endmodule

// *** verification/timer_counter_properties.sv ***
/* port checker for timer_counter: bus handshake, read data, match pulse.
   assumes: bound to timer_counter, one clock domain. */
`timescale 1ns/1ps
module timer_counter_properties #(
  parameter int FILTER_CYCLES = 8
) (
  input wire logic        clock,          // clock
  input wire logic        reset,          // async reset
  input wire logic        wb_cyc,         // cycle
  input wire logic        wb_stb,         // strobe
  input wire logic        wb_we,          // write
  input wire logic [7:0]  wb_adr,         // address
  input wire logic [3:0]  wb_sel,         // selects
  input wire logic [31:0] wb_dat_w,       // write data
  input wire logic [31:0] wb_dat_r,       // read data
  input wire logic        wb_ack,         // ack
  input wire logic        match_interrupt // match pulse
);
  logic started_q;
  wire  ctrl_wr = wb_ack && wb_we && wb_sel[0] && wb_adr[7:2] == 6'h26;
  wire  sys_stop = wb_ack && wb_we && wb_sel[0] && wb_adr[7:2] == 6'h30 && wb_dat_w[2];
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  sequence req_s;
    wb_cyc && wb_stb && !wb_ack;
  endsequence
  sequence stop_wr_s;
    (ctrl_wr && wb_dat_w[5:4] == 2'h0) || sys_stop;
  endsequence
  always_ff @(posedge clock or posedge reset) begin
    if (reset)
      started_q <= 1'b0;
    else if (ctrl_wr)
      started_q <= wb_dat_w[5:4] != 2'h0;
    else if (sys_stop)
      started_q <= 1'b0;
  end
  ack_follows_req_a: assert property (req_s |=> wb_ack)
    else $error("ack missing one cycle after request");
  ack_single_a: assert property (wb_ack |=> !wb_ack)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack |-> $past(wb_cyc) && $past(wb_stb))
    else $error("ack without request");
  rdata_upper_a: assert property (wb_ack && !wb_we |-> wb_dat_r[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  unmapped_zero_a: assert property (wb_ack && !wb_we && !(wb_adr[7:2] inside
    {6'h10, 6'h11, 6'h12, 6'h13, 6'h26, 6'h30, 6'h31, 6'h32, 6'h33})
    |-> wb_dat_r == 32'h0000_0000)
    else $error("unmapped read not zero");
  irq_single_a: assert property (match_interrupt |=> !match_interrupt [*4])
    else $error("match pulse too long or too close");
  stop_quiet_a: assert property (stop_wr_s |=> ##2 !match_interrupt [*8])
    else $error("match pulse after stop");
  irq_when_started_a: assert property (match_interrupt |-> started_q || $past(started_q))
    else $error("match pulse while stopped");
endmodule
bind timer_counter timer_counter_properties #(.FILTER_CYCLES(FILTER_CYCLES)) u_props (
  .clock(clock), .reset(reset), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
  .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
  .wb_ack(wb_ack), .match_interrupt(match_interrupt));

// *** verification/pin_source.sv ***
/* pulse source on the timer input pin.
   assumes: called from the bench clock domain. */
`timescale 1ns/1ps
module pin_source (
  input  wire logic clock, // bench clock
  output logic      pin    // timer input pin
);
  initial pin = 1'b0;
  // holds of twelve or more pass the filter; shorter only as noise or with the filter bypassed
  task automatic drive(input logic v, input int hold);
    @(posedge clock);
    pin <= v;
    repeat (hold) @(posedge clock);
  endtask
endmodule

// *** verification/test_timer_counter_trigger_modes.sv ***
/* bench for timer_counter: reads queued and compared by a monitor,
   match pulses counted and timed in clocks.
   assumes: logic/ compiled first; pin_source drives the input pin. */
`timescale 1ns/1ps
module test_timer_counter_trigger_modes;
  import timer_pkg::*;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        wb_we = 1'b0;
  logic [7:0]  wb_adr = 8'h00;
  logic [3:0]  wb_sel = 4'h0;
  logic [31:0] wb_dat_w = 32'h0000_0000;
  logic [31:0] wb_dat_r;
  logic        wb_ack;
  logic        lf = 1'b0;
  logic        pin;
  logic        irq;
  logic [7:0]  c;
  logic [7:0]  rd;
  logic [7:0]  cap_seen;
  logic [31:0] exp_q[$];
  int          errors = 0;
  int          checked = 0;
  int          cyc_n = 0;
  int          irq_cnt = 0;
  int          n;
  int          gap;
  int          base;
  always #2.5 clock = ~clock;
  always #33 lf = ~lf;
  timer_counter u_timer_counter (.clock(clock), .reset(reset), .wb_cyc(wb_cyc),
    .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
    .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
    .low_freq_clock(lf), .timer_input_pin(pin), .match_interrupt(irq));
  pin_source u_pin_source (.clock(clock), .pin(pin));
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic complete_run();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // one classic cycle; a read notes its expected byte unless q is 0
  task automatic bus(input logic w, input logic [5:0] i, input logic [7:0] d,
                     input bit q = 1'b1);
    int k;
    k = 0;
    @(posedge clock);
    if (!w && q)
      exp_q.push_back({24'h00_0000, d});
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= {i, 2'b00};
    wb_sel <= 4'h1;
    wb_dat_w <= {24'h00_0000, d};
    do begin
      @(posedge clock);
      k++;
    end while (!wb_ack && k < 20);
    rd = wb_dat_r[7:0];
    chk("ack", 1'b1, wb_ack);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task automatic wirq(input int lim, output int k);
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (irq !== 1'b1 && k < lim);
  endtask
  task automatic cmp16(input logic [7:0] v);
    bus(1'b1, 6'h10, v);
    bus(1'b1, 6'h11, 8'h00);
  endtask
  always @(posedge clock) begin
    cyc_n++;
    if (irq === 1'b1)
      irq_cnt++;
    if (wb_ack === 1'b1 && !wb_we && exp_q.size() > 0)
      chk("read data", exp_q.pop_front(), wb_dat_r);
    if (cyc_n == 60000) begin
      errors++;
      complete_run();
    end
  end
  initial begin
    void'($urandom(5086));
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    bus(1'b0, 6'h10, 8'hff);
    bus(1'b0, 6'h13, 8'hff);
    bus(1'b0, 6'h26, 8'h00);
    bus(1'b0, 6'h01, 8'h00);
    bus(1'b1, 6'h13, 8'h12);
    bus(1'b0, 6'h13, 8'hff);
    $display("test reset values done");
    bus(1'b1, 6'h26, 8'h08);
    bus(1'b1, 6'h10, 8'h05);
    repeat (20) @(posedge clock);
    bus(1'b0, 6'h10, 8'hff);
    bus(1'b1, 6'h11, 8'h00);
    repeat (20) @(posedge clock);
    bus(1'b0, 6'h10, 8'h05);
    $display("test buffered compare done");
    for (int k = 0; k < 3; k++) begin
      c = 8'h02 + 8'($urandom % 4);
      bus(1'b1, 6'h26, 8'((2 - k) << 2));
      cmp16(c);
      bus(1'b1, 6'h26, 8'(((2 - k) << 2) | 8'h10));
      wirq(20000, n);
      wirq(20000, gap);
      chk("period", (c + 1) * (8 << (4 * k)), gap);
      bus(1'b1, 6'h26, 8'((2 - k) << 2)); // stop before clock change
    end
    $display("test timer periods done");
    bus(1'b1, 6'h26, 8'h08);
    cmp16(8'h05);
    bus(1'b1, 6'h26, 8'h58);
    wirq(2000, n);
    repeat (20) @(posedge clock);
    bus(1'b0, 6'h13, 8'h00);
    bus(1'b0, 6'h12, 8'h00, 1'b0);
    chk("capture", 1'b1, rd <= 8'h05);
    bus(1'b1, 6'h30, 8'h04);
    bus(1'b0, 6'h26, 8'h48);
    base = irq_cnt;
    repeat (300) @(posedge clock);
    chk("stop irqs", 0, irq_cnt - base);
    bus(1'b0, 6'h12, 8'h00, 1'b0);
    cap_seen = rd;
    $display("test capture and stop done");
    for (int e = 0; e < 2; e++) begin
      c = 8'h14 + 8'($urandom % 8);
      bus(1'b1, 6'h26, 8'h08);
      cmp16(c);
      u_pin_source.drive(e[0], 30);
      bus(1'b1, 6'h26, e ? 8'h38 : 8'h28);
      base = irq_cnt;
      u_pin_source.drive(~e[0], 30);
      u_pin_source.drive(e[0], 30);
      u_pin_source.drive(~e[0], 30);
      u_pin_source.drive(e[0], 300);
      u_pin_source.drive(~e[0], 3);
      u_pin_source.drive(e[0], 300);
      chk("trigger irqs", 1, irq_cnt - base);
    end
    $display("test trigger start done");
    bus(1'b1, 6'h26, 8'h08);
    u_pin_source.drive(1'b0, 30);
    bus(1'b1, 6'h26, 8'h68);
    base = irq_cnt;
    u_pin_source.drive(1'b1, 40);
    u_pin_source.drive(1'b0, 300);
    chk("early stop irqs", 0, irq_cnt - base);
    u_pin_source.drive(1'b1, 300);
    chk("restart irqs", 1, irq_cnt - base);
    bus(1'b0, 6'h12, 8'h00, 1'b0);
    chk("ext no capture", cap_seen, rd);
    $display("test trigger start and stop done");
    bus(1'b1, 6'h26, 8'h08);
    bus(1'b1, 6'h30, 8'h02);
    bus(1'b1, 6'h26, 8'h00);
    cmp16(8'h02);
    u_pin_source.drive(1'b0, 10);
    bus(1'b1, 6'h26, 8'h20);
    base = irq_cnt;
    u_pin_source.drive(1'b1, 3);
    u_pin_source.drive(1'b0, 600);
    chk("bypass irqs", 1, irq_cnt - base);
    $display("test low speed bypass done");
    complete_run();
  end
endmodule
